// [psc_consts.svh]
// Offsets, lock window, reset values and timing counts of the block
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH
`define PSC_OFS_SEQ 8'h10
`define PSC_OFS_FLASH 8'h11
`define PSC_OFS_LOCK 8'h12
`define PSC_OFS_CMD 8'h13
`define PSC_OFS_PDDIS 8'h14
`define PSC_RST_SEQ 8'h00
`define PSC_RST_FLASH 8'h00
`define PSC_RST_LOCK 8'h00
`define PSC_RST_CMD 8'h00
`define PSC_RST_PDDIS 8'h00
`define PSC_LOCK_LO 9'h081
`define PSC_LOCK_HI 9'h120
`define PSC_CLK_HZ 25000000
// Ramp interval for code 00 in ns; codes halve it
`define PSC_RAMP_NS 4000
`define PSC_RAMP_CYC ((`PSC_RAMP_NS * 25) / 1000)
`define PSC_MS_CYC 25000
`define PSC_WAKE_SEC 16
`define PSC_WAKE_CYC (`PSC_WAKE_SEC * `PSC_CLK_HZ)
`define PSC_RAMP_MV 10
`endif

// [psc_pkg.sv]
// Types shared by the system control register group
package psc_pkg;
	typedef struct packed {
		logic default_supply_bit;
		logic [1:0] voltage_ramp_step_select;
		logic parameter_reload_bit;
		logic auto_start_bit;
		logic [2:0] input_filter_time_select;
	} psc_seq_t;
	typedef struct packed {
		logic [1:0] flash_on_time_select;
		logic [2:0] flash_frequency_select;
		logic [2:0] watchdog_scale_select;
	} psc_flash_t;
	typedef struct packed {
		logic voltage_lock_bit;
		logic feedback_three_select;
		logic feedback_two_select;
		logic feedback_one_select;
		logic pulsed_mode_arm_bit;
		logic [2:0] reserved;
	} psc_lock_t;
	typedef struct packed {
		logic write_en;
		logic read_en;
		logic [8:0] addr;
		logic [7:0] wdata;
	} psc_req_t;
	typedef enum logic [1:0] {
		PSC_RESET = 2'b00,
		PSC_POWERDOWN = 2'b01,
		PSC_ACTIVE = 2'b11
	} psc_mode_t;
endpackage

// [psc_regs.sv]
// System control registers of the power manager with their side effects
//
// Overview of operation
// - Default supply bit makes slot zero apply stored modes to non-core supplies.
// - Voltage ramps step 10 mV every 4, 2, 1 or 0.5 us.
// - Parameter reload bit requests nonvolatile reload when leaving power-down.
// - Auto start bit starts sequencer after reset mode, else waits for wakeup.
// - Inputs debounce for none up to 1024 ms by a three-bit code.
// - Flash on-time is 10, 20, 40 ms or 20 ms double stroke.
// - Frequency code 000 stops flashing; 001-100 give 1 s, 2 s, 4 s, 180 ms.
// - Codes 101-111 flash 2 s, 4 s, 180 ms under start supply detection.
// - Codes 001-100 need a charger; otherwise flash-on-reset gives limited flashing.
// - Watchdog scale 000 disables; others multiply base period 1x to 64x.
// - Voltage lock rejects host writes to addresses 0x81 through 0x120.
// - Feedback three select enables active-low motor brake input.
// - Feedback two outputs power good, or serves as watchdog keep-alive.
// - Feedback one shows wakeup, or drives low during mode transitions.
// - Wake command wakes from power-down; clears 16 s after entering active.
// - Shutdown command powers down to reset; clears on entering reset.
// - Host writes kick bit; device restarts watchdog and clears the bit.
// - Pin-control disable ignores enable pins in power-down; replays missed edges.
// - High-speed serial disable shuts that interface off during power-down.
// - Converter pause stops auto A0-A3 and manual measurements in power-down.
// - General input disable gates inputs in power-down; replays missed edges.
// - A disable step between 2 and max count delays the disables.
`include "psc_consts.svh"
module psc_regs #(
	parameter int WAKE_CLEAR_CYC = `PSC_WAKE_CYC,
	parameter int GPI_COUNT = 16,
	parameter int MAX_COUNT = 31
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire psc_pkg::psc_req_t host_req,
	output logic [7:0] host_rdata,
	output logic host_ack,
	output logic host_write_rejected,
	input wire psc_pkg::psc_mode_t power_mode,
	input wire logic [4:0] sequencer_slot,
	input wire logic [4:0] powerdown_disable_step,
	input wire logic mode_transition_busy,
	input wire logic start_supply_detect,
	input wire logic charger_wake_input,
	input wire logic flash_on_reset_bit,
	input wire logic flash_time_expired,
	input wire logic power_good_status,
	input wire logic wakeup_detected,
	input wire logic system_enable_pin,
	input wire logic power_enable_pin,
	input wire logic power1_enable_pin,
	input wire logic [GPI_COUNT-1:0] general_input_pin,
	input wire logic feedback_three_in,
	input wire logic feedback_two_in,
	input wire logic feedback_one_in,
	output logic apply_default_modes,
	output logic [7:0] ramp_interval_cycles,
	output logic [4:0] ramp_step_mv,
	output logic reload_request,
	output logic sequencer_start,
	output logic [2:0] input_filter_time_select,
	output logic [1:0] flash_on_time_select,
	output logic flash_enable,
	output logic [1:0] flash_period_code,
	output logic watchdog_enable,
	output logic [6:0] watchdog_multiplier,
	output logic watchdog_restart,
	output logic motor_brake_input,
	output logic feedback_two_oe,
	output logic feedback_two_out,
	output logic watchdog_keepalive_input,
	output logic feedback_one_oe,
	output logic feedback_one_out,
	output logic wake_request,
	output logic shutdown_request,
	output logic pulsed_mode_armed,
	output logic [2:0] enable_pins_seen,
	output logic enable_pins_replay,
	output logic high_speed_serial_enable,
	output logic converter_pause,
	output logic [GPI_COUNT-1:0] general_input_seen,
	output logic general_input_replay
);
	import psc_pkg::*;

	if (GPI_COUNT < 1 || GPI_COUNT > 16 || MAX_COUNT < 2 ||
		MAX_COUNT > 31 || WAKE_CLEAR_CYC < 1) begin
		$error("psc_regs: unsupported parameter values");
	end

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	psc_seq_t seq_cfg;
	psc_flash_t flash_cfg;
	psc_lock_t lock_cfg;
	logic [7:0] pddis_cfg;
	logic wake_bit;
	logic shutdown_bit;
	logic kick_bit;
	logic [31:0] wake_timer;
	logic wake_timing;
	psc_mode_t last_mode;
	logic locked_addr;
	logic write_ok;
	logic pd_effective;

	// Lock guards a window that lies outside this bank, so rejection is
	// reported rather than silently dropped
	assign locked_addr = host_req.addr >= `PSC_LOCK_LO &&
		host_req.addr <= `PSC_LOCK_HI;
	assign write_ok = host_req.write_en &&
		!(lock_cfg.voltage_lock_bit && locked_addr);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			seq_cfg <= psc_seq_t'(`PSC_RST_SEQ);
			flash_cfg <= psc_flash_t'(`PSC_RST_FLASH);
			lock_cfg <= psc_lock_t'(`PSC_RST_LOCK);
			pddis_cfg <= `PSC_RST_PDDIS;
		end else if (write_ok) begin
			if (host_req.addr == {1'b0, `PSC_OFS_SEQ}) begin
				seq_cfg <= psc_seq_t'(host_req.wdata);
			end else if (host_req.addr == {1'b0, `PSC_OFS_FLASH}) begin
				flash_cfg <= psc_flash_t'(host_req.wdata);
			end else if (host_req.addr == {1'b0, `PSC_OFS_LOCK}) begin
				lock_cfg <= psc_lock_t'(host_req.wdata);
			end else if (host_req.addr == {1'b0, `PSC_OFS_PDDIS}) begin
				pddis_cfg <= host_req.wdata & 8'h8b;
			end
		end
	end

	// ----------------------------------------------------------------
	// Self-clearing commands; a hardware clear yields to a host set
	// ----------------------------------------------------------------
	logic cmd_write;
	assign cmd_write = write_ok && host_req.addr == {1'b0, `PSC_OFS_CMD};

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			last_mode <= PSC_RESET;
		end else begin
			last_mode <= power_mode;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wake_timer <= 32'h0;
			wake_timing <= 1'b0;
		end else if (power_mode == PSC_ACTIVE && last_mode != PSC_ACTIVE) begin
			wake_timer <= 32'h0;
			wake_timing <= 1'b1;
		end else if (power_mode != PSC_ACTIVE) begin
			wake_timing <= 1'b0;
		end else if (wake_timing) begin
			wake_timer <= wake_timer + 32'h1;
			if (wake_timer == 32'(WAKE_CLEAR_CYC - 1))
				wake_timing <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wake_bit <= 1'b0;
		end else if (cmd_write && host_req.wdata[2]) begin
			wake_bit <= 1'b1;
		end else if (cmd_write) begin
			wake_bit <= 1'b0;
		end else if (wake_timing &&
			wake_timer == 32'(WAKE_CLEAR_CYC - 1)) begin
			wake_bit <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			shutdown_bit <= 1'b0;
		end else if (cmd_write && host_req.wdata[1]) begin
			shutdown_bit <= 1'b1;
		end else if (cmd_write) begin
			shutdown_bit <= 1'b0;
		end else if (power_mode == PSC_RESET && last_mode != PSC_RESET) begin
			shutdown_bit <= 1'b0;
		end
	end

	// Kick is held one cycle, restarts the timer, then clears itself
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			kick_bit <= 1'b0;
			watchdog_restart <= 1'b0;
		end else begin
			kick_bit <= cmd_write && host_req.wdata[0];
			watchdog_restart <= kick_bit;
		end
	end

	// ----------------------------------------------------------------
	// Read-back and host answer
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			host_rdata <= 8'h00;
			host_ack <= 1'b0;
			host_write_rejected <= 1'b0;
		end else begin
			host_ack <= host_req.read_en || host_req.write_en;
			host_write_rejected <= host_req.write_en && !write_ok;
			if (!host_req.read_en) begin
				host_rdata <= 8'h00;
			end else if (host_req.addr == {1'b0, `PSC_OFS_SEQ}) begin
				host_rdata <= seq_cfg;
			end else if (host_req.addr == {1'b0, `PSC_OFS_FLASH}) begin
				host_rdata <= flash_cfg;
			end else if (host_req.addr == {1'b0, `PSC_OFS_LOCK}) begin
				host_rdata <= {lock_cfg[7:3], 3'b000};
			end else if (host_req.addr == {1'b0, `PSC_OFS_CMD}) begin
				host_rdata <= {5'b00000, wake_bit, shutdown_bit, kick_bit};
			end else if (host_req.addr == {1'b0, `PSC_OFS_PDDIS}) begin
				host_rdata <= pddis_cfg;
			end else begin
				host_rdata <= 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequencer and ramp controls
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			apply_default_modes <= 1'b0;
			reload_request <= 1'b0;
			sequencer_start <= 1'b0;
			ramp_interval_cycles <= 8'h00;
			ramp_step_mv <= 5'h00;
			input_filter_time_select <= 3'h0;
		end else begin
			apply_default_modes <= seq_cfg.default_supply_bit &&
				sequencer_slot == 5'h00;
			ramp_interval_cycles <= 8'(`PSC_RAMP_CYC >>
				seq_cfg.voltage_ramp_step_select);
			ramp_step_mv <= 5'(`PSC_RAMP_MV);
			reload_request <= seq_cfg.parameter_reload_bit &&
				last_mode == PSC_POWERDOWN &&
				power_mode == PSC_ACTIVE;
			sequencer_start <= last_mode == PSC_RESET &&
				power_mode != PSC_RESET &&
				(seq_cfg.auto_start_bit || wakeup_detected);
			input_filter_time_select <= seq_cfg.input_filter_time_select;
		end
	end

	// ----------------------------------------------------------------
	// Flashing and watchdog scaling
	// ----------------------------------------------------------------
	logic [2:0] freq;
	assign freq = flash_cfg.flash_frequency_select;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			flash_on_time_select <= 2'h0;
			flash_enable <= 1'b0;
			flash_period_code <= 2'h0;
			watchdog_enable <= 1'b0;
			watchdog_multiplier <= 7'h00;
		end else begin
			flash_on_time_select <= flash_cfg.flash_on_time_select;
			if (freq == 3'b000) begin
				flash_enable <= 1'b0;
				flash_period_code <= 2'h0;
			end else if (freq <= 3'b100) begin
				flash_enable <= charger_wake_input ||
					(flash_on_reset_bit && !flash_time_expired);
				flash_period_code <= 2'(freq - 3'b001);
			end else begin
				flash_enable <= start_supply_detect;
				flash_period_code <= 2'(freq - 3'b100);
			end
			watchdog_enable <= flash_cfg.watchdog_scale_select != 3'b000;
			watchdog_multiplier <= (flash_cfg.watchdog_scale_select == 3'b000) ?
				7'h00 : 7'(7'h01 << (flash_cfg.watchdog_scale_select - 3'b001));
		end
	end

	// ----------------------------------------------------------------
	// Feedback pins and command outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			motor_brake_input <= 1'b0;
			feedback_two_oe <= 1'b0;
			feedback_two_out <= 1'b0;
			watchdog_keepalive_input <= 1'b0;
			feedback_one_oe <= 1'b0;
			feedback_one_out <= 1'b0;
			wake_request <= 1'b0;
			shutdown_request <= 1'b0;
			pulsed_mode_armed <= 1'b0;
		end else begin
			// Brake reads as released while the function is off
			motor_brake_input <= lock_cfg.feedback_three_select &&
				!feedback_three_in;
			feedback_two_oe <= !lock_cfg.feedback_two_select;
			feedback_two_out <= power_good_status;
			watchdog_keepalive_input <= lock_cfg.feedback_two_select &&
				feedback_two_in;
			feedback_one_oe <= 1'b1;
			feedback_one_out <= lock_cfg.feedback_one_select ?
				!mode_transition_busy : wakeup_detected;
			wake_request <= wake_bit && power_mode == PSC_POWERDOWN;
			shutdown_request <= shutdown_bit && power_mode != PSC_RESET;
			pulsed_mode_armed <= lock_cfg.pulsed_mode_arm_bit &&
				power_mode == PSC_RESET;
		end
	end

	// ----------------------------------------------------------------
	// Power-down auto-disables
	// ----------------------------------------------------------------
	// A step in range defers the disables until the sequencer reaches it
	assign pd_effective = power_mode == PSC_POWERDOWN &&
		(powerdown_disable_step <= 5'h01 ||
		powerdown_disable_step > 5'(MAX_COUNT) ||
		sequencer_slot <= powerdown_disable_step);

	logic pins_gated;
	logic gpi_gated;
	assign pins_gated = pd_effective && pddis_cfg[7];
	assign gpi_gated = pd_effective && pddis_cfg[0];

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			enable_pins_seen <= 3'h0;
			enable_pins_replay <= 1'b0;
			high_speed_serial_enable <= 1'b1;
			converter_pause <= 1'b0;
		end else begin
			// Seen values freeze while gated; replay flags the resume edge
			if (!pins_gated)
				enable_pins_seen <= {power1_enable_pin, power_enable_pin,
					system_enable_pin};
			enable_pins_replay <= !pins_gated && enable_pins_seen !=
				{power1_enable_pin, power_enable_pin, system_enable_pin};
			high_speed_serial_enable <= !(pd_effective && pddis_cfg[3]);
			converter_pause <= pd_effective && pddis_cfg[1];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			general_input_seen <= '0;
			general_input_replay <= 1'b0;
		end else begin
			if (!gpi_gated)
				general_input_seen <= general_input_pin;
			general_input_replay <= !gpi_gated &&
				general_input_seen != general_input_pin;
		end
	end
endmodule

// [psc_regs_asserts.sv]
// Port checks for the system control registers, bound to every instance
`include "psc_consts.svh"
// --------
// Checker
// --------
module psc_regs_chk (
	input logic sys_clk,
	input logic reset,
	input psc_pkg::psc_req_t host_req,
	input logic host_ack,
	input logic host_write_rejected,
	input psc_pkg::psc_mode_t power_mode,
	input logic [4:0] sequencer_slot,
	input logic feedback_three_in,
	input logic apply_default_modes,
	input logic [7:0] ramp_interval_cycles,
	input logic [4:0] ramp_step_mv,
	input logic reload_request,
	input logic watchdog_enable,
	input logic [6:0] watchdog_multiplier,
	input logic watchdog_restart,
	input logic motor_brake_input,
	input logic feedback_one_oe
);
	import psc_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	chk_ack_follow:
	assert property ((host_req.write_en || host_req.read_en) |=> host_ack)
		else $error("request without acknowledge");
	chk_reject_range:
	assert property (host_write_rejected |-> $past(host_req.write_en)
		&& $past(host_req.addr) >= `PSC_LOCK_LO
		&& $past(host_req.addr) <= `PSC_LOCK_HI)
		else $error("refusal outside the locked range");
	chk_slot_zero:
	assert property (apply_default_modes |-> $past(sequencer_slot) == 5'h00)
		else $error("default modes outside slot zero");
	chk_ramp_code:
	assert property ($past(!reset) |-> ramp_step_mv == 5'h0a
		&& ramp_interval_cycles inside {8'h64, 8'h32, 8'h19, 8'h0c})
		else $error("ramp step or interval off");
	chk_wd_scale:
	assert property (watchdog_enable |-> $onehot(watchdog_multiplier))
		else $error("watchdog multiplier not a power of two");
	chk_kick_restart:
	assert property (watchdog_restart |-> $past(host_req.write_en
		&& host_req.addr == {1'b0, `PSC_OFS_CMD} && host_req.wdata[0], 2))
		else $error("watchdog restart without kick");
	chk_brake_low:
	assert property (motor_brake_input |-> !$past(feedback_three_in))
		else $error("brake while input high");
	chk_ready_drive:
	assert property ($past(!reset) |-> feedback_one_oe)
		else $error("feedback one not driven");
	chk_reload_exit:
	assert property (reload_request |-> $past(power_mode, 2) == PSC_POWERDOWN
		|| $past(power_mode, 3) == PSC_POWERDOWN)
		else $error("reload without leaving power-down");
endmodule

bind psc_regs psc_regs_chk u_chk (.*);

// [psc_host_model.sv]
// Host processor model issuing single byte register requests
// --------
// Host
// --------
module psc_host_model (
	input logic sys_clk,
	output psc_pkg::psc_req_t host_req,
	input logic [7:0] host_rdata,
	input logic host_ack,
	input logic host_write_rejected
);
	import psc_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic hung;
	initial begin
		host_req = '0;
		hung = 1'b0;
	end
	// Request stands one edge; idle address and data are inverted so a
	// design that samples them outside the request sees garbage
	// The kick is a plain write of one to the command bit
	task automatic xfer(input logic wr, input logic [8:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic rej);
		logic got;
		got = 1'b0;
		q = 8'h00;
		rej = 1'b0;
		@(posedge sys_clk);
		host_req <= {wr, !wr, a, d};
		@(posedge sys_clk);
		host_req <= {1'b0, 1'b0, ~a, ~d};
		repeat (4) begin
			@(posedge sys_clk);
			if (!got && host_ack === 1'b1) begin
				q = host_rdata;
				rej = host_write_rejected;
				got = 1'b1;
			end
		end
		if (!got)
			hung = 1'b1;
	endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the system control registers
// --------
// Bench
// --------
module tb_top;
	import psc_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [8:0] a; logic [7:0] d; logic [7:0] q;} psc_row_t;
	localparam psc_row_t ROWS [5] = '{'{9'h010, 8'ha5, 8'ha5},
		'{9'h011, 8'h5a, 8'h5a}, '{9'h012, 8'h7f, 8'h78},
		'{9'h013, 8'hf8, 8'h00}, '{9'h014, 8'hff, 8'h8b}};
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	psc_req_t host_req;
	psc_mode_t power_mode;
	logic [7:0] host_rdata, ramp_interval_cycles;
	logic host_ack, host_write_rejected, mode_transition_busy;
	logic start_supply_detect, charger_wake_input, flash_on_reset_bit;
	logic flash_time_expired, power_good_status, wakeup_detected;
	logic system_enable_pin, power_enable_pin, power1_enable_pin;
	logic feedback_three_in, feedback_two_in, feedback_one_in;
	logic [4:0] sequencer_slot, powerdown_disable_step, ramp_step_mv;
	logic [15:0] general_input_pin, general_input_seen;
	logic apply_default_modes, reload_request, sequencer_start;
	logic flash_enable, watchdog_enable, watchdog_restart, motor_brake_input;
	logic feedback_two_oe, feedback_two_out, watchdog_keepalive_input;
	logic feedback_one_oe, feedback_one_out, wake_request, shutdown_request;
	logic pulsed_mode_armed, enable_pins_replay, high_speed_serial_enable;
	logic converter_pause, general_input_replay, last_rej;
	logic [2:0] input_filter_time_select, enable_pins_seen;
	logic [1:0] flash_on_time_select, flash_period_code;
	logic [6:0] watchdog_multiplier;
	int bad_count = 0;
	int total_checks = 0;
	int hits;
	int replays;
	int gpi_replays;
	psc_regs #(.WAKE_CLEAR_CYC(50)) DUT (.*);
	psc_host_model host (.*);
	always #20 sys_clk = ~sys_clk;
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic wr, input logic [8:0] a,
		input logic [7:0] d, output logic [7:0] q);
		host.xfer(wr, a, d, q, last_rej);
		if (host.hung) begin
			bad_count++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [8:0] a, input logic [7:0] e);
		logic [7:0] q;
		xfer(1'b0, a, 8'h00, q);
		check(q, e);
	endtask
	// Derived outputs land one edge after the write is taken
	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	initial begin
		power_mode = PSC_RESET;
		{mode_transition_busy, start_supply_detect, charger_wake_input} = '0;
		{flash_on_reset_bit, flash_time_expired, power_good_status} = '0;
		{wakeup_detected, system_enable_pin, power_enable_pin} = '0;
		{power1_enable_pin, feedback_three_in, feedback_two_in} = '0;
		{feedback_one_in, sequencer_slot, powerdown_disable_step} = '0;
		general_input_pin = '0;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		for (int i = 0; i < 5; i++)
			rd(ROWS[i].a, 8'h00);
		check(high_speed_serial_enable, 1);
		$display("test reset done");
		foreach (ROWS[i]) begin
			wr(ROWS[i].a, ROWS[i].d);
			rd(ROWS[i].a, ROWS[i].q);
		end
		check(input_filter_time_select, 3'h5);
		$display("test rows done");
		for (int c = 0; c < 4; c++) begin
			wr(9'h010, {1'b0, c[1:0], 5'h00});
			settle();
			check(ramp_interval_cycles, 100 >> c);
			check(ramp_step_mv, 10);
		end
		for (int c = 0; c < 8; c++) begin
			wr(9'h011, c[7:0]);
			settle();
			check(watchdog_enable, c != 0);
			if (c != 0)
				check(watchdog_multiplier, 1 << (c - 1));
		end
		$display("test ramp and watchdog done");
		@(posedge sys_clk) charger_wake_input <= 1'b1;
		wr(9'h011, 8'h08);
		settle();
		check({flash_enable, flash_period_code}, 3'b100);
		@(posedge sys_clk) charger_wake_input <= 1'b0;
		settle();
		check(flash_enable, 0);
		@(posedge sys_clk) flash_on_reset_bit <= 1'b1;
		settle();
		check(flash_enable, 1);
		@(posedge sys_clk) flash_time_expired <= 1'b1;
		settle();
		check(flash_enable, 0);
		@(posedge sys_clk) start_supply_detect <= 1'b1;
		wr(9'h011, 8'ha8);
		settle();
		check({flash_enable, flash_period_code}, 3'b101);
		check(flash_on_time_select, 2'h2);
		wr(9'h011, 8'h00);
		settle();
		check(flash_enable, 0);
		$display("test flash done");
		@(posedge sys_clk) power_good_status <= 1'b1;
		wakeup_detected <= 1'b1;
		wr(9'h012, 8'h80);
		foreach (ROWS[i]) begin
			wr(i[1] ? 9'h120 + i[0] : 9'h080 + i[0], 8'h00);
			check(last_rej, i[0] ^ i[1]);
		end
		check(feedback_two_oe, 1);
		check(feedback_two_out, 1);
		check(feedback_one_out, 1);
		check(motor_brake_input, 0);
		wr(9'h012, 8'h70);
		wr(9'h081, 8'h00);
		check(last_rej, 0);
		@(posedge sys_clk);
		mode_transition_busy <= 1'b1;
		feedback_two_in <= 1'b1;
		settle();
		check(motor_brake_input, 1);
		check(watchdog_keepalive_input, 1);
		check(feedback_one_out, 0);
		check(feedback_two_oe, 0);
		$display("test lock and feedback done");
		wr(9'h010, 8'h98);
		settle();
		check(apply_default_modes, 1);
		@(posedge sys_clk);
		sequencer_slot <= 5'h01;
		power_mode <= PSC_POWERDOWN;
		general_input_pin <= 16'h5a5a;
		{system_enable_pin, power_enable_pin, power1_enable_pin} <= 3'b111;
		hits = 0;
		repeat (4) begin
			@(posedge sys_clk);
			hits += sequencer_start;
		end
		check(hits, 1);
		check(apply_default_modes, 0);
		check(high_speed_serial_enable, 0);
		check(converter_pause, 1);
		check(general_input_seen, 0);
		check(enable_pins_seen, 0);
		wr(9'h013, 8'h04);
		settle();
		check(wake_request, 1);
		@(posedge sys_clk) power_mode <= PSC_ACTIVE;
		hits = 0;
		replays = 0;
		gpi_replays = 0;
		repeat (3) begin
			@(posedge sys_clk);
			hits += reload_request;
			replays += enable_pins_replay;
			gpi_replays += general_input_replay;
		end
		#1;
		check(hits, 1);
		check(replays, 1);
		check(gpi_replays, 1);
		check(high_speed_serial_enable, 1);
		check(general_input_seen, 16'h5a5a);
		check(enable_pins_seen, 3'b111);
		rd(9'h013, 8'h04);
		repeat (38) @(posedge sys_clk);
		rd(9'h013, 8'h04);
		rd(9'h013, 8'h00);
		$display("test power modes done");
		// The restart pulse falls inside the write, so count alongside it
		fork
			wr(9'h013, 8'h01);
			begin
				hits = 0;
				repeat (8) begin
					@(posedge sys_clk);
					hits += watchdog_restart;
				end
			end
		join
		check(hits, 1);
		rd(9'h013, 8'h00);
		wr(9'h013, 8'h02);
		settle();
		check(shutdown_request, 1);
		@(posedge sys_clk) power_mode <= PSC_RESET;
		settle();
		rd(9'h013, 8'h00);
		$display("test commands done");
		@(posedge sys_clk);
		power_mode <= PSC_POWERDOWN;
		powerdown_disable_step <= 5'h03;
		sequencer_slot <= 5'h05;
		settle();
		check(high_speed_serial_enable, 1);
		@(posedge sys_clk) sequencer_slot <= 5'h02;
		settle();
		check(high_speed_serial_enable, 0);
		$display("test disable step done");
		@(posedge sys_clk) reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		rd(9'h010, 8'h00);
		check(high_speed_serial_enable, 1);
		$display("test second reset done");
		tally_and_finish();
	end
endmodule
